// ==== lcd_keypad_command_handler.sv ====
// Command handler for a character display and keypad module
`timescale 1ns/1ps
`default_nettype none
// Function
// [RQ1] Acknowledge every command, ok or error
// [RQ2] Send key report 0x80 for enabled events
// [RQ3] Glyph command 0x09, nine bytes, index 0-7
// [RQ4] Glyph rows 0-63, msb left, top first
// [RQ5] Row byte bit 7 makes row blink
// [RQ6] Memory read 0x0A, one address byte
// [RQ7] Codes 0x40-0x7F read glyph memory
// [RQ8] Character memory lines at 0x80/0xA0/0xC0/0xE0
// [RQ9] Read answer: address then eight bytes
// [RQ10] Cursor position 0x0B, column 0-19, row 0-3
// [RQ11] Cursor style 0x0C, values 0 to 4
// [RQ12] Contrast 0x0D, values 0 to 254
// [RQ13] Backlight 0x0E, 0-100, graded brightness
// [RQ14] Raw controller write 0x16, location 0-2
// [RQ15] Key bits: up, confirm, abort, left, right, down
// [RQ16] Key reporting 0x17: press, release masks
// [RQ17] After reset report all key events
// [RQ18] Poll 0x18 returns held, pressed, released
// [RQ19] Poll ignores reporting masks
// [RQ20] Polling host should clear both masks
// [RQ21] Settings exposed and reloadable as boot state
// [RQ22] Deprecated and reserved codes not implemented
// [RQ23] Poll answer clears since-poll accumulators
// [RQ24] Bad length or range: error, no change
module lcd_keypad_command_handler
	import lcdkp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire cmd_t cmd,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output rsp_t rsp,
	input wire logic [5:0] keys_held,
	output logic mem_rd_req,
	output logic [7:0] mem_rd_addr,
	input wire logic mem_rd_ack,
	input wire logic [7:0] mem_rd_data,
	output logic lcd_wr_valid,
	output logic [1:0] lcd_wr_sel,
	output logic [7:0] lcd_wr_data,
	output logic glyph_update,
	output logic [2:0] glyph_update_idx,
	output logic [63:0] glyph_row_blink,
	output logic backlight_on,
	input wire logic boot_load,
	input wire settings_t boot_settings,
	output settings_t cur_settings
);
	typedef enum logic [0:0] {ST_IDLE, ST_READ} state_t;

	// Report code for key bit index, press or release
	function automatic logic [7:0] key_code(input logic [3:0] idx);
		logic [3:0] base;
		logic [3:0] code;
		base = (idx >= KEY_CODE_RELEASE) ? idx - KEY_CODE_RELEASE : idx;
		case (base)
			4'h0: code = 4'h1;
			4'h1: code = 4'h5;
			4'h2: code = 4'h6;
			4'h3: code = 4'h3;
			4'h4: code = 4'h4;
			default: code = 4'h2;
		endcase
		key_code = {4'h0, code} + ((idx >= KEY_CODE_RELEASE) ? 8'h06 : 8'h00);
	endfunction : key_code

	// Lowest set bit of the pending events as an index
	function automatic logic [3:0] lowest(input logic [11:0] v);
		logic [3:0] i;
		i = 4'h0;
		for (int k = 11; k >= 0; k--) begin
			if (v[k]) begin
				i = 4'(k);
			end
		end
		lowest = i;
	endfunction : lowest

	state_t state_reg, state_next;
	settings_t settings_reg, settings_next;
	rsp_t rsp_reg, rsp_next;
	logic rsp_valid_reg, rsp_valid_next;
	logic [2:0] ptr_reg, ptr_next;
	logic [7:0] rd_addr_reg, rd_addr_next;
	logic rd_glyph_reg, rd_glyph_next;
	logic lcd_wr_valid_reg, lcd_wr_valid_next;
	logic [1:0] lcd_wr_sel_reg, lcd_wr_sel_next;
	logic [7:0] lcd_wr_data_reg, lcd_wr_data_next;
	logic glyph_update_reg, glyph_update_next;
	logic [2:0] glyph_idx_reg, glyph_idx_next;
	logic [5:0] keys_prev_reg;
	logic [5:0] press_pend_reg, release_pend_reg;
	logic [5:0] press_acc_reg, release_acc_reg;
	logic ctrl_report_reg;
	logic [31:0] prdata_reg;
	logic [7:0] bl_div_reg;
	logic [6:0] bl_step_reg;
	logic backlight_on_reg;

	// Command decode
	logic take_cmd, cmd_ok, poll_clr, report_go;
	logic [7:0] d0, d1;
	logic [7:0] row_bit6;
	logic glyph_area, char_area;
	logic glyph_ok, memrd_ok, curpos_ok, cursty_ok, contrast_ok, bl_ok, raw_ok, keycfg_ok, poll_ok;
	logic [5:0] press_ev, release_ev;
	logic [11:0] pend_all, pend_clr;
	logic [3:0] pend_idx;
	logic [7:0] read_byte;
	logic read_step;

	assign d0 = cmd.data[0];
	assign d1 = cmd.data[1];
	assign cmd_ready = (state_reg == ST_IDLE) & ~rsp_valid_reg;
	assign take_cmd = cmd_valid & cmd_ready;
	genvar gr;
	generate
		for (gr = 0; gr < 8; gr++) begin : g_rows
			assign row_bit6[gr] = cmd.data[gr + 1][6]; // see [RQ4]
		end
	endgenerate
	assign glyph_ok = (cmd.len == LEN_GLYPH) && (d0 <= GLYPH_IDX_MAX) && (row_bit6 == 8'h00); // see [RQ3]
	assign glyph_area = (d0[7:6] == GLYPH_AREA); // see [RQ7]
	assign char_area = d0[7] && (d0[4:0] <= LINE_LAST); // see [RQ8]
	assign memrd_ok = (cmd.len == LEN_ONE) && (glyph_area || char_area); // see [RQ6]
	assign curpos_ok = (cmd.len == LEN_TWO) && (d0 <= COL_MAX) && (d1 <= ROW_MAX); // see [RQ10]
	assign cursty_ok = (cmd.len == LEN_ONE) && (d0 <= STYLE_MAX); // see [RQ11]
	assign contrast_ok = (cmd.len == LEN_ONE) && (d0 <= CONTRAST_MAX); // see [RQ12]
	assign bl_ok = (cmd.len == LEN_ONE) && (d0 <= BACKLIGHT_MAX); // see [RQ13]
	assign raw_ok = (cmd.len == LEN_TWO) && (d0 <= RAW_LOC_MAX); // see [RQ14]
	assign keycfg_ok = (cmd.len == LEN_TWO); // see [RQ16]
	assign poll_ok = (cmd.len == 5'h00); // see [RQ18]

	always_comb begin
		case (cmd.ctype)
			TYPE_GLYPH: cmd_ok = glyph_ok;
			TYPE_MEMRD: cmd_ok = memrd_ok;
			TYPE_CURPOS: cmd_ok = curpos_ok;
			TYPE_CURSTY: cmd_ok = cursty_ok;
			TYPE_CONTRAST: cmd_ok = contrast_ok;
			TYPE_BACKLIGHT: cmd_ok = bl_ok;
			TYPE_RAWWR: cmd_ok = raw_ok;
			TYPE_KEYCFG: cmd_ok = keycfg_ok;
			TYPE_POLL: cmd_ok = poll_ok;
			default: cmd_ok = 1'b0; // see [RQ22]
		endcase
	end

	// Key edges, reporting and poll accumulators
	assign press_ev = keys_held & ~keys_prev_reg; // see [RQ15]
	assign release_ev = ~keys_held & keys_prev_reg;
	assign pend_all = {release_pend_reg, press_pend_reg};
	assign pend_idx = lowest(pend_all);
	assign report_go = (state_reg == ST_IDLE) & ~rsp_valid_reg & ~cmd_valid & ctrl_report_reg & (|pend_all);
	assign pend_clr = report_go ? (12'h001 << pend_idx) : 12'h000;
	assign poll_clr = take_cmd & cmd_ok & (cmd.ctype == TYPE_POLL); // see [RQ23]

	// Memory read byte source
	assign read_byte = rd_glyph_reg ? settings_reg.glyph[rd_addr_reg[5:3]][rd_addr_reg[2:0]] : mem_rd_data;
	assign read_step = (state_reg == ST_READ) & (rd_glyph_reg | mem_rd_ack);
	assign mem_rd_req = (state_reg == ST_READ) & ~rd_glyph_reg;
	assign mem_rd_addr = rd_addr_reg;

	always_comb begin
		state_next = state_reg;
		settings_next = settings_reg;
		rsp_next = rsp_reg;
		rsp_valid_next = rsp_valid_reg & ~rsp_ready;
		ptr_next = ptr_reg;
		rd_addr_next = rd_addr_reg;
		rd_glyph_next = rd_glyph_reg;
		lcd_wr_valid_next = 1'b0;
		lcd_wr_sel_next = lcd_wr_sel_reg;
		lcd_wr_data_next = lcd_wr_data_reg;
		glyph_update_next = 1'b0;
		glyph_idx_next = glyph_idx_reg;
		if (take_cmd) begin
			rsp_next = '0;
			rsp_next.rtype = (cmd_ok ? RSP_OK : RSP_ERR) | {2'b00, cmd.ctype[5:0]}; // see [RQ1]
			rsp_valid_next = 1'b1;
			if (cmd_ok) begin // see [RQ24]
				case (cmd.ctype)
					TYPE_GLYPH: begin
						for (int r = 0; r < 8; r++) begin
							settings_next.glyph[d0[2:0]][r] = cmd.data[r + 1]; // see [RQ4]
						end
						glyph_update_next = 1'b1;
						glyph_idx_next = d0[2:0];
					end
					TYPE_MEMRD: begin
						rsp_next.len = LEN_MEMRD_RSP; // see [RQ9]
						rsp_next.data[0] = d0;
						rsp_valid_next = 1'b0;
						state_next = ST_READ;
						ptr_next = 3'h0;
						rd_addr_next = d0;
						rd_glyph_next = glyph_area; // see [RQ7]
					end
					TYPE_CURPOS: begin
						settings_next.cursor_col = d0[4:0]; // see [RQ10]
						settings_next.cursor_row = d1[1:0];
					end
					TYPE_CURSTY: settings_next.cursor_style = d0[2:0]; // see [RQ11]
					TYPE_CONTRAST: settings_next.contrast = d0; // see [RQ12]
					TYPE_BACKLIGHT: settings_next.backlight = d0[6:0]; // see [RQ13]
					TYPE_RAWWR: begin
						lcd_wr_valid_next = 1'b1; // see [RQ14]
						lcd_wr_sel_next = d0[1:0];
						lcd_wr_data_next = d1;
					end
					TYPE_KEYCFG: begin
						settings_next.press_mask = d0[5:0]; // see [RQ16]
						settings_next.release_mask = d1[5:0];
					end
					TYPE_POLL: begin
						rsp_next.len = LEN_POLL_RSP; // see [RQ18]
						rsp_next.data[0] = {2'b00, keys_held};
						rsp_next.data[1] = {2'b00, press_acc_reg};
						rsp_next.data[2] = {2'b00, release_acc_reg};
					end
					default: rsp_next.len = 5'h00;
				endcase
			end
		end else if (read_step) begin
			rsp_next.data[4'(ptr_reg) + 4'h1] = read_byte; // see [RQ9]
			rd_addr_next = rd_glyph_reg ? {rd_addr_reg[7:6], rd_addr_reg[5:0] + 6'h01} : rd_addr_reg + 8'h01;
			ptr_next = ptr_reg + 3'h1;
			if (ptr_reg == READ_LAST) begin
				state_next = ST_IDLE;
				rsp_valid_next = 1'b1;
			end
		end else if (report_go) begin
			rsp_next = '0;
			rsp_next.rtype = TYPE_KEYRPT; // see [RQ2]
			rsp_next.len = LEN_ONE;
			rsp_next.data[0] = key_code(pend_idx);
			rsp_valid_next = 1'b1;
		end
		if (boot_load) begin
			settings_next = boot_settings; // see [RQ21]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			settings_reg <= SETTINGS_RESET; // see [RQ17]
			rsp_reg <= '0;
			rsp_valid_reg <= 1'b0;
			ptr_reg <= 3'h0;
			rd_addr_reg <= 8'h00;
			rd_glyph_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			settings_reg <= settings_next;
			rsp_reg <= rsp_next;
			rsp_valid_reg <= rsp_valid_next;
			ptr_reg <= ptr_next;
			rd_addr_reg <= rd_addr_next;
			rd_glyph_reg <= rd_glyph_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lcd_wr_valid_reg <= 1'b0;
			lcd_wr_sel_reg <= 2'h0;
			lcd_wr_data_reg <= 8'h00;
			glyph_update_reg <= 1'b0;
			glyph_idx_reg <= 3'h0;
		end else begin
			lcd_wr_valid_reg <= lcd_wr_valid_next;
			lcd_wr_sel_reg <= lcd_wr_sel_next;
			lcd_wr_data_reg <= lcd_wr_data_next;
			glyph_update_reg <= glyph_update_next;
			glyph_idx_reg <= glyph_idx_next;
		end
	end

	// New events win over clears in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			keys_prev_reg <= 6'h00;
			press_pend_reg <= 6'h00;
			release_pend_reg <= 6'h00;
			press_acc_reg <= 6'h00;
			release_acc_reg <= 6'h00;
		end else begin
			keys_prev_reg <= keys_held;
			press_pend_reg <= (press_pend_reg & ~pend_clr[5:0]) | (press_ev & settings_reg.press_mask); // see [RQ2]
			release_pend_reg <= (release_pend_reg & ~pend_clr[11:6]) | (release_ev & settings_reg.release_mask);
			press_acc_reg <= (press_acc_reg & ~{6{poll_clr}}) | press_ev; // see [RQ19]
			release_acc_reg <= (release_acc_reg & ~{6{poll_clr}}) | release_ev; // see [RQ23]
		end
	end

	// Backlight brightness by pulse width, one step per divider tick
	logic bl_tick;
	assign bl_tick = (bl_div_reg == BL_DIV_LAST);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bl_div_reg <= 8'h00;
			bl_step_reg <= 7'h00;
			backlight_on_reg <= 1'b0;
		end else begin
			bl_div_reg <= bl_tick ? 8'h00 : bl_div_reg + 8'h01;
			if (bl_tick) begin
				bl_step_reg <= (bl_step_reg == BL_STEP_LAST) ? 7'h00 : bl_step_reg + 7'h01;
			end
			backlight_on_reg <= (settings_reg.backlight > bl_step_reg); // see [RQ13]
		end
	end

	// APB slave, zero wait states
	logic apb_setup, apb_wr, addr_hit;
	logic [31:0] rd_word;
	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pwrite;
	assign addr_hit = (paddr == REG_CTRL) | (paddr == REG_KEYS) | (paddr == REG_DISPLAY) | (paddr == REG_MASKS);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;
	always_comb begin
		case (paddr)
			REG_CTRL: rd_word = {31'h0, ctrl_report_reg};
			REG_KEYS: rd_word = {7'h0, state_reg == ST_READ, 2'h0, release_acc_reg, 2'h0, press_acc_reg, 2'h0, keys_held};
			REG_DISPLAY: rd_word = {1'b0, settings_reg.cursor_style, 2'h0, settings_reg.cursor_row, 3'h0,
				settings_reg.cursor_col, 1'b0, settings_reg.backlight, settings_reg.contrast};
			REG_MASKS: rd_word = {18'h0, settings_reg.release_mask, 2'h0, settings_reg.press_mask};
			default: rd_word = 32'h0;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_report_reg <= CTRL_RESET;
			prdata_reg <= 32'h0;
		end else begin
			if (apb_wr && paddr == REG_CTRL && pstrb[0]) begin
				ctrl_report_reg <= pwdata[0];
			end
			if (apb_setup) begin
				prdata_reg <= rd_word;
			end
		end
	end

	genvar gg;
	generate
		for (gg = 0; gg < 64; gg++) begin : g_blink
			assign glyph_row_blink[gg] = settings_reg.glyph[gg / 8][gg % 8][7]; // see [RQ5]
		end
	endgenerate

	assign prdata = prdata_reg;
	assign rsp = rsp_reg;
	assign rsp_valid = rsp_valid_reg;
	assign lcd_wr_valid = lcd_wr_valid_reg;
	assign lcd_wr_sel = lcd_wr_sel_reg;
	assign lcd_wr_data = lcd_wr_data_reg;
	assign glyph_update = glyph_update_reg;
	assign glyph_update_idx = glyph_idx_reg;
	assign backlight_on = backlight_on_reg;
	assign cur_settings = settings_reg;
endmodule : lcd_keypad_command_handler
`default_nettype wire

// ==== lcdkp_pkg.sv ====
// Shared constants and types for the display and keypad command handler
package lcdkp_pkg;
	localparam logic [7:0] TYPE_GLYPH = 8'h09;
	localparam logic [7:0] TYPE_MEMRD = 8'h0a;
	localparam logic [7:0] TYPE_CURPOS = 8'h0b;
	localparam logic [7:0] TYPE_CURSTY = 8'h0c;
	localparam logic [7:0] TYPE_CONTRAST = 8'h0d;
	localparam logic [7:0] TYPE_BACKLIGHT = 8'h0e;
	localparam logic [7:0] TYPE_RAWWR = 8'h16;
	localparam logic [7:0] TYPE_KEYCFG = 8'h17;
	localparam logic [7:0] TYPE_POLL = 8'h18;
	localparam logic [7:0] TYPE_KEYRPT = 8'h80;
	localparam logic [7:0] RSP_OK = 8'h40;
	localparam logic [7:0] RSP_ERR = 8'hc0;
	localparam logic [4:0] LEN_GLYPH = 5'h09;
	localparam logic [4:0] LEN_ONE = 5'h01;
	localparam logic [4:0] LEN_TWO = 5'h02;
	localparam logic [4:0] LEN_POLL_RSP = 5'h03;
	localparam logic [4:0] LEN_MEMRD_RSP = 5'h09;
	localparam logic [7:0] GLYPH_IDX_MAX = 8'h07;
	localparam logic [1:0] GLYPH_AREA = 2'h1;
	localparam logic [4:0] LINE_LAST = 5'h13;
	localparam logic [7:0] COL_MAX = 8'h13;
	localparam logic [7:0] ROW_MAX = 8'h03;
	localparam logic [7:0] STYLE_MAX = 8'h04;
	localparam logic [7:0] CONTRAST_MAX = 8'hfe;
	localparam logic [7:0] BACKLIGHT_MAX = 8'h64;
	localparam logic [7:0] RAW_LOC_MAX = 8'h02;
	localparam logic [3:0] KEY_CODE_RELEASE = 4'h6;
	localparam logic [2:0] READ_LAST = 3'h7;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_KEYS = 8'h04;
	localparam logic [7:0] REG_DISPLAY = 8'h08;
	localparam logic [7:0] REG_MASKS = 8'h0c;
	localparam logic CTRL_RESET = 1'b1;
	localparam int CLK_PERIOD_NS = 8;
	localparam int BL_STEP_NS = 1000;
	localparam int BL_STEP_CYCLES = BL_STEP_NS / CLK_PERIOD_NS;
	localparam logic [7:0] BL_DIV_LAST = 8'(BL_STEP_CYCLES - 1);
	localparam logic [6:0] BL_STEP_LAST = 7'h63;

	typedef struct packed {
		logic [7:0] ctype;
		logic [4:0] len;
		logic [8:0][7:0] data;
	} cmd_t;

	typedef struct packed {
		logic [7:0] rtype;
		logic [4:0] len;
		logic [8:0][7:0] data;
	} rsp_t;

	typedef struct packed {
		logic [7:0][7:0][7:0] glyph;
		logic [5:0] press_mask;
		logic [5:0] release_mask;
		logic [4:0] cursor_col;
		logic [1:0] cursor_row;
		logic [2:0] cursor_style;
		logic [7:0] contrast;
		logic [6:0] backlight;
	} settings_t;

	localparam settings_t SETTINGS_RESET = '{glyph: '0, press_mask: 6'h3f, release_mask: 6'h3f,
		cursor_col: 5'h00, cursor_row: 2'h0, cursor_style: 3'h0, contrast: 8'h5f, backlight: 7'h64};
endpackage : lcdkp_pkg

// ==== lcdkp_props.sv ====
// Checker for the command handler ports
`timescale 1ns/1ps
`default_nettype none
module lcdkp_props
	import lcdkp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pslverr,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire cmd_t cmd,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire rsp_t rsp,
	input wire logic lcd_wr_valid,
	input wire logic boot_load,
	input wire settings_t boot_settings,
	input wire settings_t cur_settings
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic take = cmd_valid && cmd_ready;
	wire logic mapped = paddr inside {REG_CTRL, REG_KEYS, REG_DISPLAY, REG_MASKS};
	a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
		else $error("response changed before acceptance");
	a_answer_next: assert property (take && cmd.ctype != TYPE_MEMRD |=> rsp_valid && rsp.rtype[5:0] == $past(cmd.ctype[5:0]))
		else $error("answer missing or wrong type");
	a_busy_refuse: assert property (rsp_valid |-> !cmd_ready)
		else $error("command taken with answer pending");
	a_apb_unmapped: assert property (psel && penable && !mapped |-> pslverr)
		else $error("unmapped access without error");
	a_range_held: assert property (cur_settings.contrast <= CONTRAST_MAX && cur_settings.backlight <= 7'h64 && cur_settings.cursor_col <= 5'h13 && cur_settings.cursor_style <= 3'h4)
		else $error("setting out of range");
	a_bad_unchanged: assert property (take && !boot_load && cmd.ctype == TYPE_CONTRAST && cmd.data[0] > CONTRAST_MAX |=> rsp.rtype == 8'hcd && $stable(cur_settings.contrast))
		else $error("bad contrast accepted");
	a_memrd_shape: assert property (rsp_valid && rsp.rtype == 8'h4a |-> rsp.len == LEN_MEMRD_RSP)
		else $error("memory read answer length");
	a_poll_shape: assert property (rsp_valid && rsp.rtype == 8'h58 |-> rsp.len == LEN_POLL_RSP)
		else $error("poll answer length");
	a_key_code: assert property (rsp_valid && rsp.rtype == TYPE_KEYRPT |-> rsp.len == LEN_ONE && rsp.data[0] inside {[1:12]})
		else $error("bad key report");
	a_wr_pulse: assert property (lcd_wr_valid |=> !lcd_wr_valid)
		else $error("controller write longer than one cycle");
	a_boot_restore: assert property (boot_load |=> cur_settings == $past(boot_settings))
		else $error("boot state not loaded");
	c_memrd: cover property (rsp_valid && rsp.rtype == 8'h4a);
	c_keyrpt: cover property (rsp_valid && rsp.rtype == TYPE_KEYRPT);
	c_error: cover property (rsp_valid && rsp.rtype[7:6] == 2'b11);
endmodule : lcdkp_props
bind lcd_keypad_command_handler lcdkp_props chk (.clk, .rst_n, .psel, .penable, .paddr, .pslverr, .cmd_valid,
	.cmd_ready, .cmd, .rsp_valid, .rsp_ready, .rsp, .lcd_wr_valid, .boot_load, .boot_settings, .cur_settings);
`default_nettype wire

// ==== lcdkp_mem_model.sv ====
// Display controller memory answering byte reads
`timescale 1ns/1ps
`default_nettype none
module lcdkp_mem_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mem_rd_req,
	input wire logic [7:0] mem_rd_addr,
	output logic mem_rd_ack,
	output logic [7:0] mem_rd_data
);
	logic [1:0] wait_reg;
	logic [7:0] data_reg;
	logic [7:0] noise_reg;
	// Odd addresses answer slowly, even ones at once
	wire logic due = wait_reg == (mem_rd_addr[0] ? 2'h3 : 2'h0);
	assign mem_rd_data = mem_rd_ack ? data_reg : noise_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 2'h0;
			mem_rd_ack <= 1'b0;
			data_reg <= 8'h00;
			noise_reg <= 8'h00;
		end else begin
			noise_reg <= noise_reg + 8'h35;
			mem_rd_ack <= 1'b0;
			if (mem_rd_req && !mem_rd_ack) begin
				wait_reg <= due ? 2'h0 : wait_reg + 2'h1;
				mem_rd_ack <= due;
				data_reg <= mem_rd_addr ^ 8'h5a;
			end
		end
	end
endmodule : lcdkp_mem_model
`default_nettype wire

// ==== test_lcd_keypad_command_handler.sv ====
// Testbench for the command handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module test_lcd_keypad_command_handler;
	import lcdkp_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, cmd_valid = 0, rsp_ready = 0, boot_load = 0;
	logic pready, pslverr, cmd_ready, rsp_valid, mem_rd_req, mem_rd_ack, lcd_wr_valid, glyph_update, backlight_on, er;
	logic [7:0] paddr = 0, mem_rd_addr, mem_rd_data, lcd_wr_data, w_dat;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic [5:0] keys_held = 0;
	logic [1:0] lcd_wr_sel, w_sel;
	logic [2:0] glyph_update_idx, g_idx;
	logic [63:0] glyph_row_blink;
	cmd_t cmd = '0;
	rsp_t rsp, r;
	settings_t boot_settings = SETTINGS_RESET, cur_settings;
	int err_count = 0, comparisons = 0, cycles = 0;
	lcd_keypad_command_handler dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp_ready, .rsp, .keys_held, .mem_rd_req,
		.mem_rd_addr, .mem_rd_ack, .mem_rd_data, .lcd_wr_valid, .lcd_wr_sel, .lcd_wr_data, .glyph_update,
		.glyph_update_idx, .glyph_row_blink, .backlight_on, .boot_load, .boot_settings, .cur_settings);
	lcdkp_mem_model mem (.clk, .rst_n, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data);
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		if (glyph_update) g_idx <= glyph_update_idx;
		if (lcd_wr_valid) begin
			w_sel <= lcd_wr_sel;
			w_dat <= lcd_wr_data;
		end
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (err_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge clk); penable <= 1;
		@(posedge clk); while (pready !== 1'b1) @(posedge clk);
		rd = prdata; er = pslverr; psel <= 0; penable <= 0;
	endtask : apb
	task automatic get_rsp(input logic [7:0] et, input logic [4:0] el);
		@(negedge clk); while (rsp_valid !== 1'b1) @(negedge clk);
		r = rsp;
		`CHK(r.rtype, et)
		`CHK(r.len, el)
		@(posedge clk) rsp_ready <= 1;
		@(posedge clk) rsp_ready <= 0;
	endtask : get_rsp
	task automatic xfer(input logic [7:0] t, input logic [4:0] l, input logic [71:0] d, input logic [7:0] et,
		input logic [4:0] el);
		@(posedge clk); cmd_valid <= 1; cmd <= {t, l, d};
		@(negedge clk); while (cmd_ready !== 1'b1) @(negedge clk);
		@(posedge clk); cmd_valid <= 0;
		get_rsp(et, el);
	endtask : xfer
	task automatic t_table();
		logic [29:0] tv [20] = '{{TYPE_CONTRAST, 5'h1, 8'hfe, 8'h0, 1'b1}, {TYPE_CONTRAST, 5'h1, 8'hff, 8'h0, 1'b0},
			{TYPE_MEMRD, 5'h1, 8'h94, 8'h0, 1'b0}, {TYPE_MEMRD, 5'h1, 8'h3f, 8'h0, 1'b0},
			{TYPE_POLL, 5'h1, 8'h0, 8'h0, 1'b0}, {TYPE_KEYCFG, 5'h1, 8'h0, 8'h0, 1'b0},
			{TYPE_CONTRAST, 5'h2, 8'h5f, 8'h0, 1'b0}, {TYPE_BACKLIGHT, 5'h1, 8'h64, 8'h0, 1'b1},
			{TYPE_BACKLIGHT, 5'h1, 8'h65, 8'h0, 1'b0}, {TYPE_CURPOS, 5'h2, 8'h13, 8'h3, 1'b1},
			{TYPE_CURPOS, 5'h2, 8'h14, 8'h0, 1'b0}, {TYPE_CURPOS, 5'h2, 8'h0, 8'h4, 1'b0},
			{TYPE_CURSTY, 5'h1, 8'h4, 8'h0, 1'b1}, {TYPE_CURSTY, 5'h1, 8'h5, 8'h0, 1'b0},
			{TYPE_RAWWR, 5'h2, 8'h3, 8'h0, 1'b0}, {TYPE_GLYPH, 5'h9, 8'h8, 8'h0, 1'b0},
			{8'h08, 5'h0, 8'h0, 8'h0, 1'b0}, {8'h0f, 5'h0, 8'h0, 8'h0, 1'b0},
			{8'h10, 5'h0, 8'h0, 8'h0, 1'b0}, {8'h15, 5'h0, 8'h0, 8'h0, 1'b0}};
		foreach (tv[i]) xfer(tv[i][29:22], tv[i][21:17], {56'h0, tv[i][8:1], tv[i][16:9]},
			{tv[i][0] ? 2'b01 : 2'b11, tv[i][27:22]}, 5'h0);
		apb(0, REG_DISPLAY, 0);
		`CHK(rd, {1'b0, 3'h4, 2'h0, 2'h3, 3'h0, 5'h13, 1'b0, 7'h64, 8'hfe})
	endtask : t_table
	task automatic t_glyph();
		xfer(TYPE_GLYPH, 5'h9, {{7{8'h3f}}, 8'h81, 8'h07}, 8'h49, 5'h0);
		`CHK(g_idx, 3'h7)
		`CHK(glyph_row_blink[57:56], 2'b01)
		xfer(TYPE_MEMRD, 5'h1, 72'h78, 8'h4a, 5'h9);
		`CHK(r.data[1:0], 16'h8178)
		`CHK(r.data[2], 8'h3f)
		xfer(TYPE_MEMRD, 5'h1, 72'h80, 8'h4a, 5'h9);
		`CHK(r.data[0], 8'h80)
		for (int i = 1; i < 9; i++) `CHK(r.data[i], (8'h7f + 8'(i)) ^ 8'h5a)
	endtask : t_glyph
	task automatic t_raw();
		for (int i = 0; i < 3; i++) begin
			xfer(TYPE_RAWWR, 5'h2, {56'h0, 8'ha0 + 8'(i), 8'(i)}, 8'h56, 5'h0);
			`CHK({w_sel, w_dat}, {2'(i), 8'ha0 + 8'(i)})
		end
	endtask : t_raw
	task automatic t_keys();
		apb(0, 8'hf0, 0);
		`CHK(er, 1'b1)
		apb(1, REG_CTRL, 0);
		keys_held <= 6'h01;
		repeat (8) @(posedge clk);
		@(negedge clk);
		`CHK(rsp_valid, 1'b0)
		apb(1, REG_CTRL, 1);
		get_rsp(TYPE_KEYRPT, 5'h1);
		`CHK(r.data[0], 8'h01)
		keys_held <= 6'h00;
		get_rsp(TYPE_KEYRPT, 5'h1);
		`CHK(r.data[0], 8'h07)
		xfer(TYPE_POLL, 5'h0, 72'h0, 8'h58, 5'h3);
		`CHK(r.data[2:0], 24'h010100)
		xfer(TYPE_KEYCFG, 5'h2, 72'h0020, 8'h57, 5'h0);
		keys_held <= 6'h20;
		get_rsp(TYPE_KEYRPT, 5'h1);
		`CHK(r.data[0], 8'h02)
		xfer(TYPE_KEYCFG, 5'h2, 72'h0, 8'h57, 5'h0);
		keys_held <= 6'h00;
		repeat (8) @(posedge clk);
		@(negedge clk);
		`CHK(rsp_valid, 1'b0)
		xfer(TYPE_POLL, 5'h0, 72'h0, 8'h58, 5'h3);
		`CHK(r.data[2:0], 24'h202000)
		xfer(TYPE_POLL, 5'h0, 72'h0, 8'h58, 5'h3);
		`CHK(r.data[2:0], 24'h000000)
	endtask : t_keys
	task automatic t_light();
		int on_cnt;
		on_cnt = 0;
		xfer(TYPE_BACKLIGHT, 5'h1, 72'h32, 8'h4e, 5'h0);
		repeat ((int'(BL_STEP_LAST) + 1) * BL_STEP_CYCLES) begin
			@(negedge clk);
			on_cnt += int'(backlight_on);
		end
		`CHK(on_cnt, 50 * BL_STEP_CYCLES)
	endtask : t_light
	task automatic t_boot();
		@(posedge clk); boot_settings.contrast <= 8'h21; boot_load <= 1;
		@(posedge clk); boot_load <= 0;
		@(negedge clk);
		`CHK(cur_settings, boot_settings)
	endtask : t_boot
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1;
		@(negedge clk);
		`CHK(cur_settings, SETTINGS_RESET)
		t_table();
		t_glyph();
		t_raw();
		t_keys();
		t_light();
		t_boot();
		report_and_stop();
	end
endmodule : test_lcd_keypad_command_handler
`default_nettype wire
